/* File: pkg/lpmc_pkg.sv */
package lpmc_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_SBY_CTRL  = 8'h00;
  localparam logic [7:0] OFF_DPSBY_CTRL = 8'h04;
  localparam logic [7:0] OFF_MSTP_A    = 8'h08;
  localparam logic [7:0] OFF_MSTP_B    = 8'h0C;
  localparam logic [7:0] OFF_MSTP_C    = 8'h10;
  localparam logic [7:0] OFF_MSTP_D    = 8'h14;
  localparam logic [7:0] OFF_PROTECT   = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int BIT_SSBY      = 0;
  localparam int BIT_DPSBY     = 0;
  localparam int BIT_ACSE      = 31;
  localparam int BIT_DMA_DTC   = 28;
  localparam int BIT_EXT_DMA   = 29;
  localparam int BIT_UNLOCK    = 1;
  localparam int BIT_ST_LOW_SPEED_ONCHIP_OSC   = 3;
  localparam int BIT_ST_DSWAKE = 4;

  // ==========================================================
  // Values after reset
  localparam logic [31:0] RST_MSTP_A = 32'hCFFF_FFFF;
  localparam logic [31:0] RST_MSTP_B = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_MSTP_C = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_MSTP_D = 32'hFFFF_FFFF;

  // ==========================================================
  // All-module stop pattern
  localparam logic [31:0] ALLSTOP_A_DONTCARE = 32'h0000_0030;
  localparam logic [31:0] ALL_ONES           = 32'hFFFF_FFFF;
  localparam logic [15:0] HALF_ONES          = 16'hFFFF;

  // ==========================================================
  // Synchronised pin vector layout
  localparam int PIN_RST    = 0;
  localparam int PIN_NMI    = 1;
  localparam int PIN_IRQ    = 2;
  localparam int PIN_DSIRQ  = 18;
  localparam int PIN_SCL    = 34;
  localparam int PIN_SDA    = 35;
  localparam int PIN_CRX    = 36;
  localparam int PIN_W      = 37;

  // ==========================================================
  // Peripheral wake sources and per-mode wake masks
  localparam int PI_TMR     = 0;
  localparam int PI_RTC_ALM = 1;
  localparam int PI_RTC_CYC = 2;
  localparam int PI_INDEPENDENT_WATCHDOG    = 3;
  localparam int PI_USB     = 4;
  localparam int PI_LVD1    = 5;
  localparam int PI_LVD2    = 6;
  localparam int PI_OSTD    = 7;
  localparam logic [7:0] WAKE_ALLSTOP = 8'hFF;
  localparam logic [7:0] WAKE_SWSTBY  = 8'h7E;
  localparam logic [7:0] WAKE_DEEP    = 8'h76;

  // ==========================================================
  // Deep standby wake reset duration
  localparam int DS_RESET_NS   = 1000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DS_RESET_CYC  = (DS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: rtl/lpmc_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - All-module stop needs enable and stop pattern (A bits 4-5 and C lower half free)
// - All-module stop wakes on listed sources
// - Wait with standby only enters software standby
// - Software standby wakes without timer, oscillator-stop
// - Wait with both selects enters deep standby
// - Deep standby wakes only on listed sources
// - Deep wake holds reset, then runs on slow oscillator
// - Modules start stopped except DMA, transfer, external DMA
// - Bit 28 gates DMA and transfer together
// - Bit 29 gates external DMA alone
// - Module-stop writes need protection unlocked
// - Power registers ignore writes unless unlock set
module lpmc_top #(
  parameter int DS_RESET_CYCLES = lpmc_pkg::DS_RESET_CYC
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        external_reset_n,
  input  wire logic        nmi_pin,
  input  wire logic [15:0] irq_pin,
  input  wire logic [15:0] deep_standby_irq_pin,
  input  wire logic        deep_standby_i2c_clock_pin,
  input  wire logic        deep_standby_i2c_data_pin,
  input  wire logic        deep_standby_can_rx_pin,
  input  wire logic [7:0]  periph_irq,
  input  wire logic        int_req,
  input  wire logic        wait_exec,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [2:0]       lp_mode,
  output logic             cpu_stop,
  output logic             internal_reset,
  output logic             low_speed_onchip_osc_sel,
  output logic             module_clk_stop_all,
  output logic             dma_ctrl_clk_en,
  output logic             external_dma_ctrl_clk_en,
  output logic [31:0]      module_stop_ctrl_a,
  output logic [31:0]      module_stop_ctrl_b,
  output logic [31:0]      module_stop_ctrl_c,
  output logic [31:0]      module_stop_ctrl_d
);

  // ==========================================================
  // Elaboration check
  if (DS_RESET_CYCLES < 1 || DS_RESET_CYCLES > 65535)
  begin : g_bad_param
    $error("DS_RESET_CYCLES out of range");
  end

  // ==========================================================
  // State and register types
  typedef enum logic [2:0] {
    LPMC_ST_RESET,
    LPMC_ST_RUN,
    LPMC_ST_SLEEP,
    LPMC_ST_ALLSTOP,
    LPMC_ST_SWSTBY,
    LPMC_ST_DEEP,
    LPMC_ST_DSRST
  } lpmc_state_t;

  typedef struct packed {
    logic [lpmc_pkg::PIN_W-1:0] pin_s1;
    logic [lpmc_pkg::PIN_W-1:0] pin_s2;
    lpmc_state_t                state;
    logic [15:0]                ds_cnt;
    logic                       ssby;
    logic                       dpsby;
    logic                       unlock;
    logic [31:0]                mstp_a;
    logic [31:0]                mstp_b;
    logic [31:0]                mstp_c;
    logic [31:0]                mstp_d;
    logic                       low_speed_onchip_osc;
    logic                       ds_wake;
    logic [31:0]                rdata;
    logic                       dma_en;
    logic                       exdma_en;
    logic                       clk_stop;
    logic                       cpu_stop;
    logic                       int_rst;
  } lpmc_regs_t;

  localparam lpmc_regs_t REGS_RST = '{
    pin_s1:   '0,
    pin_s2:   '0,
    state:    LPMC_ST_RESET,
    ds_cnt:   16'h0000,
    ssby:     1'b0,
    dpsby:    1'b0,
    unlock:   1'b0,
    mstp_a:   lpmc_pkg::RST_MSTP_A,
    mstp_b:   lpmc_pkg::RST_MSTP_B,
    mstp_c:   lpmc_pkg::RST_MSTP_C,
    mstp_d:   lpmc_pkg::RST_MSTP_D,
    low_speed_onchip_osc:     1'b0,
    ds_wake:  1'b0,
    rdata:    32'h0000_0000,
    dma_en:   1'b0,
    exdma_en: 1'b0,
    clk_stop: 1'b0,
    cpu_stop: 1'b1,
    int_rst:  1'b1
  };

  lpmc_regs_t r_r;
  lpmc_regs_t r_nxt;

  // ==========================================================
  // Helpers
  function automatic logic periph_wake(input logic [7:0] irq, input logic [7:0] mask);
    periph_wake = |(irq & mask);
  endfunction

  function automatic logic lp_write(input logic wr, input logic [7:0] addr, input logic [7:0] off,
                                    input logic unl);
    lp_write = wr && (addr == off) && unl;
  endfunction

  // ==========================================================
  // Next-state logic
  logic [lpmc_pkg::PIN_W-1:0] pins_raw;
  logic                       pin_rst_ok;
  logic                       pin_ext_wake;
  logic                       pin_deep_wake;
  logic                       allstop_ok;
  logic                       clk_running;
  logic [15:0]                ds_last;

  assign pins_raw = {deep_standby_can_rx_pin, deep_standby_i2c_data_pin, deep_standby_i2c_clock_pin,
                     deep_standby_irq_pin, irq_pin, nmi_pin, external_reset_n};
  assign ds_last  = 16'(DS_RESET_CYCLES - 1);

  always_comb
  begin
    r_nxt        = r_r;
    r_nxt.pin_s1 = pins_raw;
    r_nxt.pin_s2 = r_r.pin_s1;
    r_nxt.rdata  = 32'h0000_0000;

    pin_rst_ok    = r_r.pin_s2[lpmc_pkg::PIN_RST];
    pin_ext_wake  = r_r.pin_s2[lpmc_pkg::PIN_NMI] || (|r_r.pin_s2[lpmc_pkg::PIN_IRQ +: 16]);
    pin_deep_wake = r_r.pin_s2[lpmc_pkg::PIN_NMI] || (|r_r.pin_s2[lpmc_pkg::PIN_DSIRQ +: 16]) ||
                    r_r.pin_s2[lpmc_pkg::PIN_SCL] || r_r.pin_s2[lpmc_pkg::PIN_SDA] ||
                    r_r.pin_s2[lpmc_pkg::PIN_CRX];

    allstop_ok = r_r.mstp_a[lpmc_pkg::BIT_ACSE] &&
                 ((r_r.mstp_a | lpmc_pkg::ALLSTOP_A_DONTCARE) == lpmc_pkg::ALL_ONES) &&
                 (r_r.mstp_b == lpmc_pkg::ALL_ONES) &&
                 (r_r.mstp_c[31:16] == lpmc_pkg::HALF_ONES) &&
                 (r_r.mstp_d == lpmc_pkg::ALL_ONES);

    // ========================================================
    // Register writes
    if (r_r.state == LPMC_ST_RUN)
    begin
      if (reg_wr && reg_addr == lpmc_pkg::OFF_PROTECT)
      begin
        r_nxt.unlock = reg_wdata[lpmc_pkg::BIT_UNLOCK];
      end
      if (lp_write(reg_wr, reg_addr, lpmc_pkg::OFF_SBY_CTRL, r_r.unlock))
      begin
        r_nxt.ssby = reg_wdata[lpmc_pkg::BIT_SSBY];
      end
      if (lp_write(reg_wr, reg_addr, lpmc_pkg::OFF_DPSBY_CTRL, r_r.unlock))
      begin
        r_nxt.dpsby = reg_wdata[lpmc_pkg::BIT_DPSBY];
      end
      if (lp_write(reg_wr, reg_addr, lpmc_pkg::OFF_MSTP_A, r_r.unlock))
      begin
        r_nxt.mstp_a = reg_wdata;
      end
      if (lp_write(reg_wr, reg_addr, lpmc_pkg::OFF_MSTP_B, r_r.unlock))
      begin
        r_nxt.mstp_b = reg_wdata;
      end
      if (lp_write(reg_wr, reg_addr, lpmc_pkg::OFF_MSTP_C, r_r.unlock))
      begin
        r_nxt.mstp_c = reg_wdata;
      end
      if (lp_write(reg_wr, reg_addr, lpmc_pkg::OFF_MSTP_D, r_r.unlock))
      begin
        r_nxt.mstp_d = reg_wdata;
      end
    end

    // ========================================================
    // Register reads
    if (reg_rd)
    begin
      case (reg_addr)
        lpmc_pkg::OFF_SBY_CTRL:   r_nxt.rdata[lpmc_pkg::BIT_SSBY] = r_r.ssby;
        lpmc_pkg::OFF_DPSBY_CTRL: r_nxt.rdata[lpmc_pkg::BIT_DPSBY] = r_r.dpsby;
        lpmc_pkg::OFF_MSTP_A:     r_nxt.rdata = r_r.mstp_a;
        lpmc_pkg::OFF_MSTP_B:     r_nxt.rdata = r_r.mstp_b;
        lpmc_pkg::OFF_MSTP_C:     r_nxt.rdata = r_r.mstp_c;
        lpmc_pkg::OFF_MSTP_D:     r_nxt.rdata = r_r.mstp_d;
        lpmc_pkg::OFF_PROTECT:    r_nxt.rdata[lpmc_pkg::BIT_UNLOCK] = r_r.unlock;
        lpmc_pkg::OFF_STATUS:
        begin
          r_nxt.rdata[2:0]                    = r_r.state;
          r_nxt.rdata[lpmc_pkg::BIT_ST_LOW_SPEED_ONCHIP_OSC]  = r_r.low_speed_onchip_osc;
          r_nxt.rdata[lpmc_pkg::BIT_ST_DSWAKE] = r_r.ds_wake;
        end
        default:                  r_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // ========================================================
    // Mode sequencer
    case (r_r.state)
      LPMC_ST_RESET:
      begin
        if (pin_rst_ok)
        begin
          r_nxt.state = LPMC_ST_RUN;
        end
      end
      LPMC_ST_RUN:
      begin
        if (wait_exec)
        begin
          if (r_r.ssby && r_r.dpsby)
          begin
            r_nxt.state = LPMC_ST_DEEP;
          end
          else if (r_r.ssby)
          begin
            r_nxt.state = LPMC_ST_SWSTBY;
          end
          else if (allstop_ok)
          begin
            r_nxt.state = LPMC_ST_ALLSTOP;
          end
          else
          begin
            r_nxt.state = LPMC_ST_SLEEP;
          end
        end
      end
      LPMC_ST_SLEEP:
      begin
        if (int_req || pin_ext_wake || (|periph_irq))
        begin
          r_nxt.state = LPMC_ST_RUN;
        end
      end
      LPMC_ST_ALLSTOP:
      begin
        if (pin_ext_wake || periph_wake(periph_irq, lpmc_pkg::WAKE_ALLSTOP))
        begin
          r_nxt.state = LPMC_ST_RUN;
        end
      end
      LPMC_ST_SWSTBY:
      begin
        if (pin_ext_wake || periph_wake(periph_irq, lpmc_pkg::WAKE_SWSTBY))
        begin
          r_nxt.state = LPMC_ST_RUN;
        end
      end
      LPMC_ST_DEEP:
      begin
        if (pin_deep_wake || periph_wake(periph_irq, lpmc_pkg::WAKE_DEEP))
        begin
          r_nxt.state  = LPMC_ST_DSRST;
          r_nxt.ds_cnt = 16'h0000;
        end
      end
      LPMC_ST_DSRST:
      begin
        if (r_r.ds_cnt == ds_last)
        begin
          r_nxt         = REGS_RST;
          r_nxt.pin_s1  = pins_raw;
          r_nxt.pin_s2  = r_r.pin_s1;
          r_nxt.state   = LPMC_ST_RUN;
          r_nxt.low_speed_onchip_osc    = 1'b1;
          r_nxt.ds_wake = 1'b1;
        end
        else
        begin
          r_nxt.ds_cnt = r_r.ds_cnt + 16'h0001;
        end
      end
      default:
      begin
        r_nxt.state = LPMC_ST_RESET;
      end
    endcase

    // External reset pin low overrides everything
    if (!pin_rst_ok)
    begin
      r_nxt        = REGS_RST;
      r_nxt.pin_s1 = pins_raw;
      r_nxt.pin_s2 = r_r.pin_s1;
    end

    // ========================================================
    // Module clock gating
    clk_running = (r_nxt.state == LPMC_ST_RUN) || (r_nxt.state == LPMC_ST_SLEEP);
    r_nxt.clk_stop = !clk_running;
    r_nxt.dma_en   = clk_running && !r_nxt.mstp_a[lpmc_pkg::BIT_DMA_DTC];
    r_nxt.exdma_en = clk_running && !r_nxt.mstp_a[lpmc_pkg::BIT_EXT_DMA];
    // Registered status outputs
    r_nxt.cpu_stop = r_nxt.state != LPMC_ST_RUN;
    r_nxt.int_rst  = (r_nxt.state == LPMC_ST_RESET) || (r_nxt.state == LPMC_ST_DSRST);
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_r <= REGS_RST;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata                = r_r.rdata;
  assign lp_mode                  = r_r.state;
  assign cpu_stop                 = r_r.cpu_stop;
  assign internal_reset           = r_r.int_rst;
  assign low_speed_onchip_osc_sel = r_r.low_speed_onchip_osc;
  assign module_clk_stop_all      = r_r.clk_stop;
  assign dma_ctrl_clk_en          = r_r.dma_en;
  assign external_dma_ctrl_clk_en = r_r.exdma_en;
  assign module_stop_ctrl_a       = r_r.mstp_a;
  assign module_stop_ctrl_b       = r_r.mstp_b;
  assign module_stop_ctrl_c       = r_r.mstp_c;
  assign module_stop_ctrl_d       = r_r.mstp_d;

endmodule

/* File: testbench/lpmc_properties.sv */
`timescale 1ns/10ps
// ==========
// Mode checker
module lpmc_props #(
  parameter int DS_RESET_CYCLES = 2
) (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        wait_exec,
  input wire logic        int_req,
  input wire logic [7:0]  periph_irq,
  input wire logic [2:0]  lp_mode,
  input wire logic        cpu_stop,
  input wire logic        internal_reset,
  input wire logic        low_speed_onchip_osc_sel,
  input wire logic        dma_ctrl_clk_en,
  input wire logic        external_dma_ctrl_clk_en,
  input wire logic [31:0] module_stop_ctrl_a,
  input wire logic [31:0] module_stop_ctrl_b
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_cpu_stop_map: assert property (cpu_stop == (lp_mode != 3'h1)) else $error("bad cpu_stop");
  a_wait_leaves_run: assert property (lp_mode == 3'h1 && wait_exec |=> lp_mode inside {[3'h2:3'h5]})
    else $error("wait ignored");
  a_sleep_wake: assert property (lp_mode == 3'h2 && int_req |=> lp_mode == 3'h1) else $error("sleep stuck");
  a_allstop_wake: assert property (lp_mode == 3'h3 && periph_irq != 8'h00 |=> lp_mode == 3'h1)
    else $error("all-stop stuck");
  a_swstby_wake: assert property (lp_mode == 3'h4 && (periph_irq & 8'h7E) != 8'h00 |=> lp_mode == 3'h1)
    else $error("standby stuck");
  a_deep_wake: assert property (lp_mode == 3'h5 && (periph_irq & 8'h76) != 8'h00 |=> lp_mode == 3'h6 && internal_reset)
    else $error("deep stuck");
  a_deep_reset_end: assert property (lp_mode == 3'h5 ##1 lp_mode == 3'h6 |-> ##[1:1000] lp_mode == 3'h1)
    else $error("deep reset hangs");
  a_deep_exit_osc: assert property ($fell(lp_mode == 3'h6) |-> lp_mode == 3'h1 && low_speed_onchip_osc_sel)
    else $error("no slow osc");
  a_run_reset_vals: assert property (lp_mode == 3'h1 && $past(lp_mode) inside {3'h0, 3'h6} |->
    module_stop_ctrl_a == 32'hCFFF_FFFF && module_stop_ctrl_b == 32'hFFFF_FFFF) else $error("bad reset value");
  a_dma_gate: assert property (lp_mode == 3'h1 && $past(lp_mode) == 3'h1 |->
    dma_ctrl_clk_en == !module_stop_ctrl_a[28]) else $error("bad dma gate");
  a_xdma_gate: assert property (lp_mode == 3'h1 && $past(lp_mode) == 3'h1 |->
    external_dma_ctrl_clk_en == !module_stop_ctrl_a[29]) else $error("bad ext dma gate");
  c_sleep: cover property (lp_mode == 3'h2 ##1 lp_mode == 3'h1);
  c_allstop: cover property (lp_mode == 3'h3 ##1 lp_mode == 3'h1);
  c_deep: cover property (lp_mode == 3'h6 ##1 lp_mode == 3'h1);
endmodule

bind lpmc_top lpmc_props #(.DS_RESET_CYCLES(DS_RESET_CYCLES)) u_props (
  .mclk, .arst_n, .wait_exec, .int_req, .periph_irq, .lp_mode, .cpu_stop, .internal_reset,
  .low_speed_onchip_osc_sel, .dma_ctrl_clk_en, .external_dma_ctrl_clk_en, .module_stop_ctrl_a, .module_stop_ctrl_b
);

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  // ==========
  // Signals
  logic             mclk, arst_n, external_reset_n, int_req, wait_exec, reg_wr, reg_rd, nmi_fb;
  logic [13:0]      src, mk;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, module_stop_ctrl_a, module_stop_ctrl_b, module_stop_ctrl_c;
  logic [31:0]      module_stop_ctrl_d;
  logic [2:0]       lp_mode;
  logic             cpu_stop, internal_reset, low_speed_onchip_osc_sel, module_clk_stop_all;
  logic             dma_ctrl_clk_en, external_dma_ctrl_clk_en;
  wire logic        nmi_pin, deep_standby_i2c_clock_pin, deep_standby_i2c_data_pin, deep_standby_can_rx_pin;
  wire logic [15:0] irq_pin, deep_standby_irq_pin;
  wire logic [7:0]  periph_irq;
  int               mismatches, cmp_count, m, i;

  assign periph_irq = src[7:0];
  assign irq_pin = {15'h0000, src[8]};
  assign nmi_pin = src[9] | nmi_fb;
  assign deep_standby_irq_pin = {15'h0000, src[10]};
  assign deep_standby_i2c_clock_pin = src[11];
  assign deep_standby_i2c_data_pin = src[12];
  assign deep_standby_can_rx_pin = src[13];

  lpmc_top #(.DS_RESET_CYCLES(8)) dut (
    .mclk, .arst_n, .external_reset_n, .nmi_pin, .irq_pin, .deep_standby_irq_pin, .deep_standby_i2c_clock_pin,
    .deep_standby_i2c_data_pin, .deep_standby_can_rx_pin, .periph_irq, .int_req, .wait_exec, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lp_mode, .cpu_stop, .internal_reset, .low_speed_onchip_osc_sel,
    .module_clk_stop_all, .dma_ctrl_clk_en, .external_dma_ctrl_clk_en, .module_stop_ctrl_a, .module_stop_ctrl_b,
    .module_stop_ctrl_c, .module_stop_ctrl_d
  );

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic wait_mode(input logic [2:0] e);
    int n;
    #1;
    for (n = 0; n < 300 && lp_mode !== e; n++)
    begin
      @(posedge mclk);
      #1;
    end
    chk(32'(lp_mode), 32'(e));
  endtask

  task automatic enter(input logic [31:0] a, input logic s, input logic d, input logic [2:0] e);
    wr(8'h18, 32'h0000_0002);
    wr(8'h00, {31'h0000_0000, s});
    wr(8'h04, {31'h0000_0000, d});
    wr(8'h08, a);
    @(posedge mclk);
    wait_exec <= 1'b1;
    @(posedge mclk);
    wait_exec <= 1'b0;
    wait_mode(e);
    chk(32'(module_clk_stop_all), 32'(e != 3'h2));
    chk(32'(cpu_stop), 32'h1);
  endtask

  task automatic sleep_case(input logic [31:0] a);
    enter(a, 1'b0, 1'b0, 3'h2);
    @(posedge mclk);
    int_req <= 1'b1;
    wait_mode(3'h1);
    @(posedge mclk);
    int_req <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========
  // Clock, watchdog, tests
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    give_verdict;
  end

  initial
  begin
    {arst_n, int_req, wait_exec, reg_wr, reg_rd, nmi_fb} = 6'h00;
    external_reset_n = 1'b1;
    src = 14'h0000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    wait_mode(3'h1);
    rd(8'h08, 32'hCFFF_FFFF);
    rd(8'h0C, 32'hFFFF_FFFF);
    rd(8'h14, 32'hFFFF_FFFF);
    chk(module_stop_ctrl_b, 32'hFFFF_FFFF);
    chk(module_stop_ctrl_d, 32'hFFFF_FFFF);
    chk(32'(dma_ctrl_clk_en & external_dma_ctrl_clk_en), 32'h1);
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'hCFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    wr(8'h18, 32'h0000_0002);
    wr(8'h08, 32'hDFFF_FFFF);
    chk(module_stop_ctrl_a, 32'hDFFF_FFFF);
    rd(8'h08, 32'hDFFF_FFFF);
    chk({30'h0, dma_ctrl_clk_en, external_dma_ctrl_clk_en}, 32'h1);
    wr(8'h08, 32'hEFFF_FFFF);
    rd(8'h08, 32'hEFFF_FFFF);
    chk({30'h0, dma_ctrl_clk_en, external_dma_ctrl_clk_en}, 32'h2);
    rd(8'h1C, 32'h0000_0001);
    sleep_case(32'hCFFF_FFFF);
    sleep_case(32'h7FFF_FFCF);
    sleep_case(32'hFFFF_FF8F);
    wr(8'h10, 32'hFFFF_0000);
    chk(module_stop_ctrl_c, 32'hFFFF_0000);
    enter(32'hFFFF_FFFF, 1'b0, 1'b0, 3'h3);
    @(posedge mclk);
    int_req <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(32'(lp_mode), 32'h3);
    @(posedge mclk);
    int_req <= 1'b0;
    nmi_fb <= 1'b1;
    wait_mode(3'h1);
    @(posedge mclk);
    nmi_fb <= 1'b0;
    for (m = 3; m <= 5; m++)
      for (i = 0; i < 14; i++)
      begin
        enter(m == 3 ? 32'hFFFF_FFCF : 32'hCFFF_FFFF, m >= 4, m == 5, 3'(m));
        mk = m == 3 ? 14'h03FF : (m == 4 ? 14'h037E : 14'h3E76);
        @(posedge mclk);
        src <= 14'h0001 << i;
        repeat (4) @(posedge mclk);
        #1;
        chk(32'(lp_mode), !mk[i] ? 32'(m) : (m == 5 ? 32'h6 : 32'h1));
        if (m == 5 && mk[i])
          chk(32'(internal_reset), 32'h1);
        @(posedge mclk);
        src <= 14'h0000;
        nmi_fb <= !mk[i];
        wait_mode(3'h1);
        @(posedge mclk);
        nmi_fb <= 1'b0;
        if (m == 5)
          rd(8'h1C, 32'h0000_0019);
      end
    @(posedge mclk);
    external_reset_n <= 1'b0;
    wait_mode(3'h0);
    chk(32'(internal_reset), 32'h1);
    @(posedge mclk);
    external_reset_n <= 1'b1;
    wait_mode(3'h1);
    chk(32'(low_speed_onchip_osc_sel), 32'h0);
    rd(8'h08, 32'hCFFF_FFFF);
    give_verdict;
  end
endmodule
